// File: core/pwm_pkg.sv
// Purpose: constants shared by the dual edge pwm timer
// Assumes: 32-bit register port, word aligned byte offsets
// Notes:   all offsets and field positions live here
package pwm_pkg;
	localparam int unsigned DW = 32;
	localparam int unsigned NM = 7;
	localparam int unsigned NOUT = 6;
	localparam int unsigned NCAP = 2;
	localparam logic [7:0] OFS_STATUS  = 8'h00;
	localparam logic [7:0] OFS_CTRL    = 8'h04;
	localparam logic [7:0] OFS_COUNT   = 8'h08;
	localparam logic [7:0] OFS_PRE_LIM = 8'h0c;
	localparam logic [7:0] OFS_PRE_CNT = 8'h10;
	localparam logic [7:0] OFS_ACTION  = 8'h14;
	localparam logic [7:0] OFS_SOURCE  = 8'h18;
	localparam logic [7:0] OFS_OUTSEL  = 8'h1c;
	localparam logic [7:0] OFS_RELEASE = 8'h20;
	localparam logic [7:0] OFS_MASK    = 8'h24;
	localparam logic [7:0] OFS_MATCH   = 8'h40;
	localparam logic [7:0] OFS_MATCH_END = 8'h5c;
	// control fields
	localparam int unsigned CTRL_RUN    = 0;
	localparam int unsigned CTRL_CLR    = 1;
	localparam int unsigned CTRL_PWM    = 2;
	localparam int unsigned CTRL_FOLLOW = 3;
	localparam int unsigned CTRL_W      = 4;
	// per match action, three bits each
	localparam int unsigned ACT_INT  = 0;
	localparam int unsigned ACT_RST  = 1;
	localparam int unsigned ACT_STOP = 2;
	localparam int unsigned ACT_W    = 3;
	// count source fields
	localparam int unsigned SRC_CNT  = 0;
	localparam int unsigned SRC_RISE = 1;
	localparam int unsigned SRC_FALL = 2;
	localparam int unsigned SRC_SEL  = 3;
	localparam int unsigned SRC_W    = 4;
	// output select: double-edge bits, then enable bits
	localparam int unsigned OUT_DBL = 0;
	localparam int unsigned OUT_EN  = 8;
	localparam logic [31:0] RST_WORD = 32'h0;
endpackage

// File: core/dual_edge_pwm_timer.sv
// Purpose: timer/counter with seven matches driving six pwm outputs
// Assumes: CLK_SYS 125 MHz, RESET synchronous active high
// Notes:   SYNC_IN comes from a master unit on the same clock
`timescale 1ns/100ps
module dual_edge_pwm_timer #(
	parameter int unsigned CW = pwm_pkg::DW
) (
	input  logic                      CLK_SYS,
	input  logic                      RESET,
	input  logic [7:0]                ADDR,
	input  logic [31:0]               WDATA,
	input  logic                      WR,
	input  logic                      RD,
	output logic [31:0]               RDATA,
	input  logic [pwm_pkg::NCAP-1:0]  CAP_IN,
	input  logic                      SYNC_IN,
	output logic [pwm_pkg::NOUT-1:0]  PWM_OUT,
	output logic                      IRQ,
	output logic                      SYNC_OUT
);
	localparam int unsigned NM = pwm_pkg::NM;
	localparam int unsigned NO = pwm_pkg::NOUT;

	if (CW < 2 || CW > 32) begin : g_bad_width
		$error("count width must lie in 2..32");
	end

	logic [CW-1:0]             tc;
	logic [CW-1:0]             pc;
	logic [CW-1:0]             pre_lim;
	logic [pwm_pkg::CTRL_W-1:0] ctrl;
	logic [pwm_pkg::SRC_W-1:0] src;
	logic [NM*pwm_pkg::ACT_W-1:0] action;
	logic [15:0]               outsel;
	logic [NM-1:0]             release_q;
	logic [NM-1:0]             status;
	logic [NM-1:0]             mask;
	logic [CW-1:0]             shadow [NM];
	logic [CW-1:0]             act [NM];
	logic [NO-1:0]             pwm_q;
	logic [pwm_pkg::NCAP-1:0]  cap_s1;
	logic [pwm_pkg::NCAP-1:0]  cap_s2;
	logic [pwm_pkg::NCAP-1:0]  cap_s3;

	// register decode
	wire wr_status  = WR && ADDR == pwm_pkg::OFS_STATUS;
	wire wr_ctrl    = WR && ADDR == pwm_pkg::OFS_CTRL;
	wire wr_pre_lim = WR && ADDR == pwm_pkg::OFS_PRE_LIM;
	wire wr_action  = WR && ADDR == pwm_pkg::OFS_ACTION;
	wire wr_source  = WR && ADDR == pwm_pkg::OFS_SOURCE;
	wire wr_outsel  = WR && ADDR == pwm_pkg::OFS_OUTSEL;
	wire wr_release = WR && ADDR == pwm_pkg::OFS_RELEASE;
	wire wr_mask    = WR && ADDR == pwm_pkg::OFS_MASK;
	wire hit_match  = ADDR >= pwm_pkg::OFS_MATCH
		&& ADDR < pwm_pkg::OFS_MATCH_END && ADDR[1:0] == 2'h0;
	wire [7:0] moff = ADDR - pwm_pkg::OFS_MATCH;
	wire [2:0] midx = moff[4:2];
	wire wr_match   = WR && hit_match;

	// control decode
	wire pwm_mode = ctrl[pwm_pkg::CTRL_PWM];
	wire follow   = ctrl[pwm_pkg::CTRL_FOLLOW];
	wire clr      = ctrl[pwm_pkg::CTRL_CLR];
	// a slave only counts while the master's run level is high
	wire run = ctrl[pwm_pkg::CTRL_RUN] && (!follow || SYNC_IN);

	// capture input edge, read only from the second stage onward
	wire cap_now  = cap_s2[src[pwm_pkg::SRC_SEL]];
	wire cap_prev = cap_s3[src[pwm_pkg::SRC_SEL]];
	wire cap_edge = (src[pwm_pkg::SRC_RISE] && cap_now && !cap_prev)
		|| (src[pwm_pkg::SRC_FALL] && !cap_now && cap_prev);
	wire src_ev = src[pwm_pkg::SRC_CNT] ? cap_edge : 1'b1;
	wire pre_wrap = pc == pre_lim;
	wire inc = run && src_ev && pre_wrap;

	// match events and their actions
	logic [NM-1:0] mev;
	logic [NM-1:0] act_int;
	logic [NM-1:0] act_rst;
	logic [NM-1:0] act_stop;
	for (genvar i = 0; i < NM; i++) begin : g_match
		assign mev[i] = inc && tc == act[i];
		assign act_int[i] = action[i*pwm_pkg::ACT_W + pwm_pkg::ACT_INT];
		assign act_rst[i] = action[i*pwm_pkg::ACT_W + pwm_pkg::ACT_RST];
		assign act_stop[i] = action[i*pwm_pkg::ACT_W + pwm_pkg::ACT_STOP];
	end
	// in pwm mode match 0 always closes the cycle
	wire per_event = pwm_mode && mev[0];
	wire rst_hit = |(mev & act_rst) || per_event;
	wire stop_hit = |(mev & act_stop);
	wire [NM-1:0] irq_set = mev & act_int;

	wire [CW-1:0] next_pc = clr ? '0
		: (run && src_ev) ? (pre_wrap ? '0 : pc + 1'b1) : pc;
	wire [CW-1:0] next_tc = clr ? '0
		: inc ? (rst_hit ? '0 : tc + 1'b1) : tc;

	logic [pwm_pkg::CTRL_W-1:0] ctrl_wr;
	assign ctrl_wr = wr_ctrl ? WDATA[pwm_pkg::CTRL_W-1:0] : ctrl;
	wire [pwm_pkg::CTRL_W-1:0] next_ctrl = (stop_hit && !wr_ctrl)
		? (ctrl_wr & ~(pwm_pkg::CTRL_W'(1) << pwm_pkg::CTRL_RUN))
		: ctrl_wr;

	// sticky status: a new event beats a write-one clear
	wire [NM-1:0] w1c = wr_status ? WDATA[NM-1:0] : '0;
	// irq follows the mask written this cycle, so a write beside an event
	// cannot leave the level one cycle behind the status
	wire [NM-1:0] next_mask = wr_mask ? WDATA[NM-1:0] : mask;
	wire [NM-1:0] next_status = (status & ~w1c) | irq_set;
	// release bits: hardware clears on transfer, a fresh write wins
	wire [NM-1:0] rel_set = wr_release ? WDATA[NM-1:0] : '0;
	wire [NM-1:0] rel_done = per_event ? release_q : '0;
	wire [NM-1:0] next_release = (release_q & ~rel_done) | rel_set;

	// outputs: single edge rises at period start, double on match n-1
	logic [NO-1:0] next_pwm;
	for (genvar k = 0; k < NO; k++) begin : g_out
		wire dbl = (k > 0) && outsel[pwm_pkg::OUT_DBL + k];
		wire zero = act[k+1] == '0;
		wire set_e = dbl ? mev[k] : (mev[0] && !zero);
		wire clr_e = mev[k+1];
		wire on = pwm_mode && outsel[pwm_pkg::OUT_EN + k];
		assign next_pwm[k] = !on ? 1'b0
			: clr_e ? 1'b0 : set_e ? 1'b1 : pwm_q[k];
	end

	// read mux
	wire [31:0] rd_mux =
		ADDR == pwm_pkg::OFS_STATUS  ? 32'(status)
		: ADDR == pwm_pkg::OFS_CTRL    ? 32'(ctrl)
		: ADDR == pwm_pkg::OFS_COUNT   ? 32'(tc)
		: ADDR == pwm_pkg::OFS_PRE_LIM ? 32'(pre_lim)
		: ADDR == pwm_pkg::OFS_PRE_CNT ? 32'(pc)
		: ADDR == pwm_pkg::OFS_ACTION  ? 32'(action)
		: ADDR == pwm_pkg::OFS_SOURCE  ? 32'(src)
		: ADDR == pwm_pkg::OFS_OUTSEL  ? 32'(outsel)
		: ADDR == pwm_pkg::OFS_RELEASE ? 32'(release_q)
		: ADDR == pwm_pkg::OFS_MASK    ? 32'(mask)
		: hit_match ? 32'(shadow[midx])
		: pwm_pkg::RST_WORD;

	always_ff @(posedge CLK_SYS) begin
		cap_s1 <= CAP_IN;
		cap_s2 <= cap_s1;
		cap_s3 <= cap_s2;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tc <= '0;
			pc <= '0;
			ctrl <= '0;
			status <= '0;
			release_q <= '0;
			pwm_q <= '0;
		end else begin
			tc <= next_tc;
			pc <= next_pc;
			ctrl <= next_ctrl;
			status <= next_status;
			release_q <= next_release;
			pwm_q <= next_pwm;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pre_lim <= '0;
			action <= '0;
			src <= '0;
			outsel <= '0;
			mask <= '0;
		end else begin
			if (wr_pre_lim) pre_lim <= WDATA[CW-1:0];
			if (wr_action) action <= WDATA[NM*pwm_pkg::ACT_W-1:0];
			if (wr_source) src <= WDATA[pwm_pkg::SRC_W-1:0];
			if (wr_outsel) outsel <= WDATA[15:0];
			if (wr_mask) mask <= next_mask;
		end
	end

	// shadow takes writes; the live copy follows at once in timer
	// mode, and only at a released period boundary in pwm mode
	for (genvar i = 0; i < NM; i++) begin : g_mreg
		wire w = wr_match && midx == 3'(i);
		always_ff @(posedge CLK_SYS) begin
			if (RESET) begin
				shadow[i] <= '0;
				act[i] <= '0;
			end else begin
				if (w) shadow[i] <= WDATA[CW-1:0];
				if (!pwm_mode && w)
					act[i] <= WDATA[CW-1:0];
				else if (rel_done[i])
					act[i] <= shadow[i];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			RDATA <= '0;
			IRQ <= 1'b0;
			SYNC_OUT <= 1'b0;
		end else begin
			RDATA <= RD ? rd_mux : '0;
			IRQ <= |(next_status & next_mask);
			SYNC_OUT <= next_ctrl[pwm_pkg::CTRL_RUN];
		end
	end

	assign PWM_OUT = pwm_q;

	// checks
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	a_period_reset: assert property (
		per_event && !clr |=> tc == '0)
		else $error("count not cleared by period match");
	a_single_rise: assert property (
		pwm_mode && outsel[pwm_pkg::OUT_EN] && mev[0]
		&& act[1] != '0 && !mev[1] |=> PWM_OUT[0])
		else $error("single edge output did not rise");
	a_const_low: assert property (
		act[1] == '0 && mev[0] |=> !PWM_OUT[0])
		else $error("zero width output went high");
	a_double_edges: assert property (
		pwm_mode && outsel[pwm_pkg::OUT_DBL + 1]
		&& outsel[pwm_pkg::OUT_EN + 1] && mev[1] && !mev[2]
		|=> PWM_OUT[1])
		else $error("double edge output missed its rise");
	a_double_fall: assert property (
		mev[2] |=> !PWM_OUT[1])
		else $error("output stayed high past its fall match");
	a_stop_match: assert property (
		stop_hit && !WR |=> !ctrl[pwm_pkg::CTRL_RUN] ##1 $stable(tc))
		else $error("timer kept running after stop match");
	a_irq_sticky: assert property (
		irq_set[0] |=> status[0] && (mask[0] -> IRQ))
		else $error("match interrupt flag not raised");
	a_release_hold: assert property (
		pwm_mode && !rel_done[0] |=> $stable(act[0]))
		else $error("match value changed without release");
	a_release_take: assert property (
		rel_done[0] |=> act[0] == $past(shadow[0]) && !release_q[0]
		|| $past(wr_release))
		else $error("released match value not applied");
	a_timer_quiet: assert property (
		!pwm_mode |=> PWM_OUT == '0)
		else $error("pwm output driven in timer mode");
	a_prescale_step: assert property (
		inc && !clr && !rst_hit |=> pc == '0 && tc == $past(tc) + 1'b1)
		else $error("prescaler wrap did not step the count");
	a_follow_hold: assert property (
		follow && !SYNC_IN && !clr |=> $stable(tc) && $stable(pc))
		else $error("slave counted without the master running");
	a_irq_level: assert property (
		IRQ == |(status & mask))
		else $error("interrupt level disagrees with status and mask");
	a_out_disabled: assert property (
		!outsel[pwm_pkg::OUT_EN] |=> !PWM_OUT[0])
		else $error("disabled output was driven");
	a_counter_src: assert property (
		src[pwm_pkg::SRC_CNT] && !cap_edge && !clr |=> $stable(pc))
		else $error("counter mode moved without an edge");

	c_period: cover property (per_event ##1 !per_event ##[1:64] per_event);
	c_release: cover property (rel_done != '0);
	c_stop: cover property (stop_hit);
	c_counter: cover property (src[pwm_pkg::SRC_CNT] && inc);
	c_follow: cover property (follow && SYNC_IN && inc);
endmodule // dual_edge_pwm_timer

// File: testbench/pin_partner.sv
// Purpose: pin side model, capture pulses in, pwm loads out
// Assumes: shares the timer clock
// Notes:   high cycles of each output are counted while meas is high
`timescale 1ns/100ps
module pin_partner (
	input  logic       clk,
	input  logic       meas,
	input  logic [5:0] pwm,
	output logic [1:0] cap,
	output int         hi [6]
);
	initial cap = 2'h0;
	always @(posedge clk) begin
		for (int k = 0; k < 6; k++) begin
			hi[k] <= meas ? hi[k] + int'(pwm[k]) : 0;
		end
	end
	// slow edges: the pin is synchronised, so keep each level at least 4 cycles
	task automatic pulse(input int n, input int b);
		repeat (n) begin
			@(posedge clk) cap[b] <= 1'b1;
			repeat (4) @(posedge clk);
			cap[b] <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
endmodule // pin_partner

// File: testbench/dual_edge_pwm_timer_tb_top.sv
// Purpose: register level tests of the pwm timer
// Assumes: CLK_SYS 8 ns, synchronous active high reset
// Notes:   SYNC_IN is driven by the bench to play the master unit
`timescale 1ns/100ps
module dual_edge_pwm_timer_tb_top;
	logic        clk;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr_s;
	logic        rd_s;
	logic [31:0] rdata;
	logic [1:0]  cap;
	logic [5:0]  pwm;
	logic        irq;
	logic        sync_out;
	logic        meas;
	logic        sync_in;
	int          hi [6];
	int          n_mismatch;
	int          tests_run;
	// match 0..6; output 5 gets a negative pulse, output 2 stays low
	logic [31:0] mv [7] = '{32'h4, 32'h2, 32'h0, 32'h1, 32'h3, 32'h3, 32'h1};
	int          exp_hi [6] = '{6, 0, 0, 4, 0, 6};

	dual_edge_pwm_timer i_dual_edge_pwm_timer (
		.CLK_SYS(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .CAP_IN(cap),
		.SYNC_IN(sync_in), .PWM_OUT(pwm), .IRQ(irq), .SYNC_OUT(sync_out));
	pin_partner i_pin_partner (
		.clk(clk), .meas(meas), .pwm(pwm), .cap(cap), .hi(hi));

	always #4 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// ten pwm samples counted by the pin model
	task automatic win();
		@(posedge clk) meas <= 1'b1;
		repeat (10) @(posedge clk);
		meas <= 1'b0;
		#1;
	endtask
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		clk = 0; rst = 1; addr = 0; wdata = 0; wr_s = 0; rd_s = 0; meas = 0;
		sync_in = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(pwm_pkg::OFS_CTRL, 0);
		rd(pwm_pkg::OFS_COUNT, 0);
		rd(8'h3c, 0);
		// counter mode, rising edges of capture 0, divide by two
		wr(pwm_pkg::OFS_PRE_LIM, 32'h1);
		wr(pwm_pkg::OFS_SOURCE, 32'h3);
		wr(pwm_pkg::OFS_CTRL, 32'h1);
		i_pin_partner.pulse(4, 0);
		repeat (10) @(posedge clk);
		rd(pwm_pkg::OFS_COUNT, 32'h2);
		rd(pwm_pkg::OFS_PRE_CNT, 0);
		// falling edges of capture 1
		wr(pwm_pkg::OFS_CTRL, 32'h2);
		wr(pwm_pkg::OFS_SOURCE, 32'hd);
		wr(pwm_pkg::OFS_CTRL, 32'h1);
		i_pin_partner.pulse(4, 1);
		repeat (10) @(posedge clk);
		rd(pwm_pkg::OFS_COUNT, 32'h2);
		// pwm mode: shadows loaded, nothing moves before release
		wr(pwm_pkg::OFS_SOURCE, 0);
		wr(pwm_pkg::OFS_PRE_LIM, 0);
		wr(pwm_pkg::OFS_OUTSEL, 32'h2b28);
		wr(pwm_pkg::OFS_ACTION, 32'h1);
		wr(pwm_pkg::OFS_CTRL, 32'h6);
		for (int i = 0; i < 7; i++) wr(pwm_pkg::OFS_MATCH + 8'(4 * i), mv[i]);
		wr(pwm_pkg::OFS_CTRL, 32'h5);
		repeat (20) @(posedge clk);
		win();
		for (int k = 0; k < 6; k++) chk(hi[k], 0);
		wr(pwm_pkg::OFS_RELEASE, 32'h7f);
		repeat (20) @(posedge clk);
		rd(pwm_pkg::OFS_RELEASE, 0);
		win();
		for (int k = 0; k < 6; k++) chk(hi[k], exp_hi[k]);
		chk(sync_out, 1);
		chk(irq, 0);
		wr(pwm_pkg::OFS_MASK, 32'h1);
		repeat (3) @(posedge clk);
		#1;
		chk(irq, 1);
		wr(pwm_pkg::OFS_CTRL, 0);
		wr(pwm_pkg::OFS_STATUS, 32'h7f);
		rd(pwm_pkg::OFS_STATUS, 0);
		chk(irq, 0);
		// timer mode, match 1 stops the timer
		wr(pwm_pkg::OFS_ACTION, 32'h20);
		wr(pwm_pkg::OFS_CTRL, 32'h2);
		wr(pwm_pkg::OFS_CTRL, 32'h1);
		repeat (20) @(posedge clk);
		rd(pwm_pkg::OFS_CTRL, 0);
		chk(pwm, 0);
		// slave: counts only while the master's run level is high
		wr(pwm_pkg::OFS_ACTION, 0);
		wr(pwm_pkg::OFS_CTRL, 32'h2);
		wr(pwm_pkg::OFS_CTRL, 32'h9);
		repeat (4) @(posedge clk);
		rd(pwm_pkg::OFS_COUNT, 0);
		@(posedge clk) sync_in <= 1'b1;
		repeat (5) @(posedge clk);
		sync_in <= 1'b0;
		repeat (2) @(posedge clk);
		rd(pwm_pkg::OFS_COUNT, 32'h5);
		end_of_test();
	end
endmodule // dual_edge_pwm_timer_tb_top
